// ---- src/aocr_pkg.sv ----
// constants, field layout and types of the output configuration register bank
// assumes a 125 MHz system clock and a three-wire serial register port
package aocr_pkg;

	// register addresses as carried in the low 13 bits of the 16-bit serial instruction
	localparam logic [12:0] ADDR_FORMAT = 13'h0014;
	localparam logic [12:0] ADDR_DRIVE = 13'h0015;
	localparam logic [12:0] ADDR_PHASE = 13'h0016;
	localparam logic [12:0] ADDR_PAT_LO = 13'h0019;
	localparam logic [12:0] ADDR_PAT_HI = 13'h001A;

	// reset values
	localparam logic [7:0] RST_FORMAT = 8'h00;
	localparam logic [7:0] RST_DRIVE = 8'h00;
	localparam logic [7:0] RST_PHASE = 8'h03;
	localparam logic [7:0] RST_PAT_LO = 8'h00;
	localparam logic [7:0] RST_PAT_HI = 8'h00;

	// implemented bits; all others read as zero
	localparam logic [7:0] MASK_FORMAT = 8'h47;
	localparam logic [7:0] MASK_DRIVE = 8'h30;
	localparam logic [7:0] MASK_PHASE = 8'h0F;

	// field positions
	localparam int FMT_LOWPWR_BIT = 6;
	localparam int FMT_INVERT_BIT = 2;
	localparam int FMT_CODE_LSB = 0;
	localparam int DRV_TERM_LSB = 4;
	localparam int PHASE_LSB = 0;

	// field codes
	localparam logic [1:0] CODE_OFFSET = 2'h0;
	localparam logic [1:0] CODE_TWOS = 2'h1;
	localparam logic [3:0] PHASE_MAX = 4'hA;
	localparam int PHASE_STEP_DEG = 60;
	localparam int PHASE_TAPS = 11;
	localparam int LATCH_TAP = 0;
	localparam logic [3:0] TEST_USER = 4'h8;

	// serial frame: 16 instruction bits then 8 data bits
	localparam logic [4:0] INSTR_BITS = 5'h10;
	localparam logic [4:0] FRAME_BITS = 5'h18;
	localparam int INSTR_RW_BIT = 15;

	// configuration seen by the output path
	typedef struct packed {
		logic low_power;
		logic invert;
		logic [1:0] coding;
		logic [1:0] drive;
		logic [3:0] phase;
		logic [15:0] pattern;
	} aocr_cfg_s;

	typedef enum {ST_INSTR, ST_WDATA, ST_RDATA, ST_DONE} aocr_spi_e;

endpackage : aocr_pkg

// ---- src/aocr_regs.sv ----
// output format, drive, clock phase and user pattern registers with their
// serial register port and the output data path they steer
// assumes serial pins are asynchronous and sclk is well below clk_sys_i / 4
`timescale 1ns/10ps

// Notes on behaviour
// R1 - format: bit 6 low-power signalling, bit 2 invert, bits 1:0 coding
// R2 - clock phase is bits 3:0, codes 0 to 10, reset code 3
// R3 - each phase step delays the output clock a further 60 degrees
// R4 - phase picks the divider tap only; sample latching timing never changes
// R5 - low user pattern byte is a full 8-bit register, reset zero
// R6 - high user pattern byte is a separate 8-bit register, reset zero
// R7 - test mode code 1000 puts the user pattern on the outputs
module aocr_regs import aocr_pkg::*; #(
	parameter int DATA_W = 12
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_sdio_i,
	output logic spi_sdio_o,
	output logic spi_sdio_oe_o,
	input wire logic [3:0] test_mode_i,
	input wire logic [DATA_W-1:0] sample_i,
	input wire logic [PHASE_TAPS-1:0] phase_tap_i,
	output aocr_cfg_s cfg_o,
	output logic out_clk_o,
	output logic latch_clk_o,
	output logic [15:0] data_o
);

	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic [2:0] sync_c;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_n;
	logic sdi;
	aocr_spi_e state;
	aocr_spi_e next_state;
	logic [4:0] bit_cnt;
	logic [4:0] next_bit_cnt;
	logic [15:0] instr;
	logic [15:0] next_instr;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic sdo;
	logic next_sdo;
	logic wr_en;
	logic [7:0] wr_data;
	logic [7:0] reg_format;
	logic [7:0] reg_drive;
	logic [7:0] reg_phase;
	logic [7:0] reg_pat_lo;
	logic [7:0] reg_pat_hi;
	logic [7:0] next_format;
	logic [7:0] next_drive;
	logic [7:0] next_phase;
	logic [7:0] next_pat_lo;
	logic [7:0] next_pat_hi;
	logic next_out_clk;
	logic next_latch_clk;
	logic [15:0] next_data;

	// read-back value of an address, unmapped reads as zero
	function automatic logic [7:0] read_reg(input logic [12:0] addr);
		logic [7:0] val;
		val = 8'h00;
		case (addr)
			ADDR_FORMAT: val = reg_format;
			ADDR_DRIVE: val = reg_drive;
			ADDR_PHASE: val = reg_phase;
			ADDR_PAT_LO: val = reg_pat_lo;
			ADDR_PAT_HI: val = reg_pat_hi;
			default: val = 8'h00;
		endcase
		return val;
	endfunction : read_reg

	// two-stage synchronisers for the serial pins, third stage for edges
	always_ff @(posedge clk_sys_i) begin
		sync_a <= {spi_sclk_i, spi_cs_n_i, spi_sdio_i};
		sync_b <= sync_a;
		sync_c <= sync_b;
	end

	assign sclk_rise = sync_b[2] & ~sync_c[2];
	assign sclk_fall = ~sync_b[2] & sync_c[2];
	assign cs_n = sync_b[1];
	assign sdi = sync_b[0];

	// serial frame sequencer: instruction, then write or read data byte
	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_instr = instr;
		next_shreg = shreg;
		next_sdo = sdo;
		wr_en = 1'b0;
		wr_data = {shreg[6:0], sdi};
		if (cs_n) begin
			next_state = ST_INSTR;
			next_bit_cnt = 5'h00;
			next_sdo = 1'b0;
		end else begin
			case (state)
				ST_INSTR: begin
					if (sclk_rise) begin
						next_instr = {instr[14:0], sdi};
						next_bit_cnt = bit_cnt + 5'h01;
						if (bit_cnt == INSTR_BITS - 5'h01) begin
							if (instr[INSTR_RW_BIT-1]) begin
								next_state = ST_RDATA;
								next_shreg = read_reg({instr[11:0], sdi});
							end else begin
								next_state = ST_WDATA;
							end
						end
					end
				end
				ST_WDATA: begin
					if (sclk_rise) begin
						next_shreg = wr_data;
						next_bit_cnt = bit_cnt + 5'h01;
						if (bit_cnt == FRAME_BITS - 5'h01) begin
							wr_en = 1'b1;
							next_state = ST_DONE;
						end
					end
				end
				ST_RDATA: begin
					if (sclk_fall) begin
						next_sdo = shreg[7];
						next_shreg = {shreg[6:0], 1'b0};
					end
					if (sclk_rise) begin
						next_bit_cnt = bit_cnt + 5'h01;
						if (bit_cnt == FRAME_BITS - 5'h01) begin
							next_state = ST_DONE;
						end
					end
				end
				ST_DONE: next_state = ST_DONE;
				default: next_state = ST_INSTR;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state <= ST_INSTR;
			bit_cnt <= 5'h00;
			instr <= 16'h0000;
			shreg <= 8'h00;
			sdo <= 1'b0;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			instr <= next_instr;
			shreg <= next_shreg;
			sdo <= next_sdo;
		end
	end

	assign spi_sdio_o = sdo;
	assign spi_sdio_oe_o = (state == ST_RDATA) & ~cs_n; // drive only in read

	// register writes, reserved bits masked to zero
	always_comb begin
		next_format = reg_format;
		next_drive = reg_drive;
		next_phase = reg_phase;
		next_pat_lo = reg_pat_lo;
		next_pat_hi = reg_pat_hi;
		if (wr_en) begin
			case (instr[12:0])
				ADDR_FORMAT: next_format = wr_data & MASK_FORMAT; // R1
				ADDR_DRIVE: next_drive = wr_data & MASK_DRIVE;
				ADDR_PHASE: begin
					// codes above the last tap are ignored
					if ((wr_data & MASK_PHASE) <= {4'h0, PHASE_MAX}) begin
						next_phase = wr_data & MASK_PHASE; // R2
					end
				end
				ADDR_PAT_LO: next_pat_lo = wr_data; // R5
				ADDR_PAT_HI: next_pat_hi = wr_data; // R6
				default: next_format = reg_format;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			reg_format <= RST_FORMAT; // R1
			reg_drive <= RST_DRIVE;
			reg_phase <= RST_PHASE; // R2
			reg_pat_lo <= RST_PAT_LO; // R5
			reg_pat_hi <= RST_PAT_HI; // R6
		end else begin
			reg_format <= next_format;
			reg_drive <= next_drive;
			reg_phase <= next_phase;
			reg_pat_lo <= next_pat_lo;
			reg_pat_hi <= next_pat_hi;
		end
	end

	// configuration fields for the output stage
	assign cfg_o = '{reg_format[FMT_LOWPWR_BIT], reg_format[FMT_INVERT_BIT],
		reg_format[FMT_CODE_LSB +: 2], reg_drive[DRV_TERM_LSB +: 2],
		reg_phase[PHASE_LSB +: 4], {reg_pat_hi, reg_pat_lo}}; // R1 R6

	// output data: user pattern or formatted sample, then optional invert
	always_comb begin
		next_data = 16'h0000;
		next_data[DATA_W-1:0] = sample_i;
		if (cfg_o.coding == CODE_TWOS) begin
			next_data[DATA_W-1] = ~sample_i[DATA_W-1]; // R1
		end
		if (test_mode_i == TEST_USER) begin
			next_data = cfg_o.pattern; // R7
		end
		if (cfg_o.invert) begin
			next_data = ~next_data; // R1
		end
		// each tap is one 60 degree step later than the one before
		next_out_clk = phase_tap_i[cfg_o.phase]; // R3
		next_latch_clk = phase_tap_i[LATCH_TAP]; // R4
	end

	// both clocks take the same register delay so their relation is kept
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			data_o <= 16'h0000;
			out_clk_o <= 1'b0;
			latch_clk_o <= 1'b0;
		end else begin
			data_o <= next_data;
			out_clk_o <= next_out_clk;
			latch_clk_o <= next_latch_clk;
		end
	end

	sequence s_low_write;
		wr_en && instr[12:0] == ADDR_PAT_LO;
	endsequence

	sequence s_high_write;
		wr_en && instr[12:0] == ADDR_PAT_HI;
	endsequence

	AST_FMT_RESET: assert property (@(posedge clk_sys_i) // R1
		srst_i |=> (cfg_o.coding == CODE_OFFSET && !cfg_o.invert
		&& !cfg_o.low_power))
		else $error("format not cleared by reset");

	AST_TWOS_CODING: assert property (@(posedge clk_sys_i) // R1
		disable iff (srst_i)
		(test_mode_i != TEST_USER && cfg_o.coding == CODE_TWOS
		&& !cfg_o.invert) |=> data_o[DATA_W-1] == !$past(sample_i[DATA_W-1]))
		else $error("twos complement msb wrong");

	AST_PHASE_RESET: assert property (@(posedge clk_sys_i) // R2
		srst_i |=> cfg_o.phase == RST_PHASE[3:0])
		else $error("phase reset code wrong");

	AST_PHASE_LEGAL: assert property (@(posedge clk_sys_i) // R2
		disable iff (srst_i) cfg_o.phase <= PHASE_MAX)
		else $error("phase code out of range");

	AST_PHASE_TAP: assert property (@(posedge clk_sys_i) // R3
		disable iff (srst_i)
		(!srst_i && $stable(cfg_o.phase)) ##1 $stable(cfg_o.phase)
		|-> out_clk_o == $past(phase_tap_i[cfg_o.phase]))
		else $error("output clock not on selected tap");

	AST_LATCH_FIXED: assert property (@(posedge clk_sys_i) // R4
		disable iff (srst_i)
		$changed(cfg_o.phase) |=> latch_clk_o == $past(phase_tap_i[LATCH_TAP]))
		else $error("latch timing moved with phase");

	AST_PAT_LOW: assert property (@(posedge clk_sys_i) // R5
		disable iff (srst_i)
		s_low_write |=> reg_pat_lo == $past(wr_data) && $stable(reg_pat_hi))
		else $error("low pattern byte not stored");

	AST_PAT_HIGH: assert property (@(posedge clk_sys_i) // R6
		disable iff (srst_i)
		s_high_write |=> cfg_o.pattern[15:8] == $past(wr_data)
		&& $stable(reg_pat_lo))
		else $error("high pattern byte not stored");

	AST_USER_OUT: assert property (@(posedge clk_sys_i) // R7
		disable iff (srst_i)
		(test_mode_i == TEST_USER && !cfg_o.invert)
		|=> data_o == $past(cfg_o.pattern))
		else $error("user pattern not on outputs");

endmodule : aocr_regs

// ---- test/aocr_regs_tb.sv ----
// self-checking bench for the output configuration register bank
// assumes the bench drives every port itself; serial bits go six clocks
// per sclk half period
`timescale 1ns/10ps
module aocr_regs_tb import aocr_pkg::*; ;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic sclk = 1'b0;
	logic cs_n = 1'b1;
	logic tb_sdio = 1'b0;
	logic [3:0] test_mode = 4'h0;
	logic [11:0] sample = 12'h000;
	logic [10:0] tap = 11'h000;
	logic sdio_o;
	logic sdio_oe;
	logic out_clk;
	logic latch_clk;
	logic [15:0] data;
	aocr_cfg_s cfg;
	logic sdio_wire;
	logic [7:0] q;
	logic [7:0] fmt_tab [4];
	logic [15:0] exp_tab [4];
	int errors = 0;
	int checked = 0;

	// wire level of the two-way data pin
	assign sdio_wire = sdio_oe ? sdio_o : tb_sdio;

	aocr_regs DUT (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.spi_sclk_i(sclk),
		.spi_cs_n_i(cs_n),
		.spi_sdio_i(sdio_wire),
		.spi_sdio_o(sdio_o),
		.spi_sdio_oe_o(sdio_oe),
		.test_mode_i(test_mode),
		.sample_i(sample),
		.phase_tap_i(tap),
		.cfg_o(cfg),
		.out_clk_o(out_clk),
		.latch_clk_o(latch_clk),
		.data_o(data)
	);

	// one comparison, reported on mismatch
	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// one serial bit: low half, sample wire, high half
	task bit_step(input logic b);
		sclk <= 1'b0;
		tb_sdio <= b;
		repeat (6) @(posedge clk_sys_i);
		q = {q[6:0], sdio_wire};
		sclk <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
	endtask : bit_step

	// whole frame: 16 instruction bits then 8 data bits, msb first
	task xfer(input logic rd, input logic [12:0] a, input logic [7:0] d);
		logic [15:0] ins;
		ins = {rd, 2'b00, a};
		cs_n <= 1'b0;
		@(posedge clk_sys_i);
		for (int i = 15; i >= 0; i--) begin
			bit_step(ins[i]);
		end
		for (int i = 7; i >= 0; i--) begin
			bit_step(d[i]);
			if (rd) begin
				// drive ends with the last rising edge of the frame
				chk("sdio_oe", 16'(i > 0), 16'(sdio_oe));
			end
		end
		sclk <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		cs_n <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
	endtask : xfer

	task rd_chk(input string name, input logic [12:0] a, input logic [7:0] e);
		xfer(1'b1, a, 8'h00);
		chk(name, 16'(e), 16'(q));
	endtask : rd_chk

	task conclude();
		if (errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	// free-running system clock
	initial begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	// hang guard, well beyond the expected run length
	initial begin
		repeat (40000) @(posedge clk_sys_i);
		errors++;
		conclude();
	end

	// main sequence
	initial begin
		fmt_tab = '{8'h00, 8'h01, 8'h02, 8'h04};
		exp_tab = '{16'h0123, 16'h0923, 16'h0123, 16'hFEDC};
		repeat (5) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		@(posedge clk_sys_i);
		rd_chk("format", ADDR_FORMAT, 8'h00);
		rd_chk("drive", ADDR_DRIVE, 8'h00);
		rd_chk("phase", ADDR_PHASE, 8'h03);
		rd_chk("pat_lo", ADDR_PAT_LO, 8'h00);
		rd_chk("pat_hi", ADDR_PAT_HI, 8'h00);
		rd_chk("unmapped", 13'h0017, 8'h00);
		xfer(1'b0, ADDR_FORMAT, 8'hFF);
		rd_chk("format", ADDR_FORMAT, 8'h47);
		chk("fmt_fields", 16'h000F,
			16'({cfg.low_power, cfg.invert, cfg.coding}));
		xfer(1'b0, ADDR_DRIVE, 8'hFF);
		rd_chk("drive", ADDR_DRIVE, 8'h30);
		chk("drv_field", 16'h0003, 16'(cfg.drive));
		// coding and invert on live samples
		sample <= 12'h123;
		for (int i = 0; i < 4; i++) begin
			xfer(1'b0, ADDR_FORMAT, fmt_tab[i]);
			repeat (2) @(posedge clk_sys_i);
			chk("data", exp_tab[i], data);
		end
		// user pattern, still inverted, then plain
		xfer(1'b0, ADDR_PAT_LO, 8'hA5);
		xfer(1'b0, ADDR_PAT_HI, 8'h3C);
		rd_chk("pat_lo", ADDR_PAT_LO, 8'hA5);
		rd_chk("pat_hi", ADDR_PAT_HI, 8'h3C);
		test_mode <= TEST_USER;
		repeat (2) @(posedge clk_sys_i);
		chk("data_pat", 16'hC35A, data);
		xfer(1'b0, ADDR_FORMAT, 8'h00);
		chk("data_pat", 16'h3CA5, data);
		// every legal phase code selects its tap, latching stays on tap 0
		for (int n = 0; n <= 10; n++) begin
			xfer(1'b0, ADDR_PHASE, 8'(n));
			rd_chk("phase", ADDR_PHASE, 8'(n));
			tap <= 11'(1) << n;
			repeat (3) @(posedge clk_sys_i);
			chk("out_clk", 16'h0001, 16'(out_clk));
			chk("latch_clk", 16'(n == 0), 16'(latch_clk));
		end
		xfer(1'b0, ADDR_PHASE, 8'h0B);
		rd_chk("phase", ADDR_PHASE, 8'h0A);
		// reset in mid-run brings back the defaults
		srst_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		chk("data_rst", 16'h0000, data);
		rd_chk("phase", ADDR_PHASE, 8'h03);
		rd_chk("drive", ADDR_DRIVE, 8'h00);
		rd_chk("pat_lo", ADDR_PAT_LO, 8'h00);
		rd_chk("pat_hi", ADDR_PAT_HI, 8'h00);
		conclude();
	end
endmodule : aocr_regs_tb
